// file: verilog/cbt_pkg.sv
/*
 * Constants and types for the bit timing block: register map, field
 * layout, reset values, bus levels and state codes.
 * Assumes a 32-bit AXI4-Lite slave port and a 25 MHz peripheral clock.
 */
`default_nettype none
package cbt_pkg;
   // ==========================================================
   // Clock and bit rate
   localparam int unsigned CLK_HZ           = 25_000_000;
   localparam int unsigned MAX_BIT_RATE_BPS = 1_000_000;
   localparam int unsigned MIN_CLKS_PER_BIT = CLK_HZ / MAX_BIT_RATE_BPS;

   // ==========================================================
   // Register map
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  OFS_BIT_TIMING  = 4'h0;
   localparam logic [3:0]  OFS_CONTROL     = 4'h4;
   localparam logic [3:0]  OFS_STATUS      = 4'h8;

   // Bit timing register fields, each stored as value minus one
   localparam int          PRESC_LSB       = 0;
   localparam int          PRESC_W         = 5;
   localparam int          SJW_LSB         = 6;
   localparam int          SJW_W           = 2;
   localparam int          FIRST_TIMING_SEGMENT_FIELD_LSB       = 8;
   localparam int          FIRST_TIMING_SEGMENT_FIELD_W         = 4;
   localparam int          SECOND_TIMING_SEGMENT_FIELD_LSB       = 12;
   localparam int          SECOND_TIMING_SEGMENT_FIELD_W         = 3;
   localparam logic [31:0] BTR_MASK        = 32'h0000_7FDF;
   localparam logic [31:0] BTR_RST         = 32'h0000_2300;

   // Control and status fields
   localparam int          CTRL_INIT_BIT   = 0;
   localparam int          STAT_SAMPLE_BIT = 0;
   localparam int          STAT_HARD_BIT   = 1;
   localparam int          STAT_RESYNC_BIT = 2;
   localparam int          STAT_STATE_LSB  = 4;
   localparam int          STAT_PERR_LSB   = 8;

   // ==========================================================
   // Bus levels, responses, counters
   localparam logic        LVL_DOMINANT    = 1'b0;
   localparam logic        LVL_RECESSIVE   = 1'b1;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   localparam int          CNT_W           = 5;
   localparam logic [4:0]  CNT_ONE         = 5'h01;

   typedef enum logic [2:0] {
      ST_SYNC  = 3'h1,
      ST_FIRST_TIMING_SEGMENT_FIELD = 3'h2,
      ST_SECOND_TIMING_SEGMENT_FIELD = 3'h4
   } cbt_btl_state_type;
endpackage
`default_nettype wire

// file: verilog/cbt_tq_if.sv
/*
 * Link between the bit timing logic and the time quantum prescaler.
 * Assumes both ends run on the same peripheral clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface cbt_tq_if;
   logic [cbt_pkg::PRESC_W-1:0] presc_field;
   logic                        run;
   logic                        tick;
   modport btl (output presc_field, output run, input tick);
   modport gen (input presc_field, input run, output tick);
endinterface
`default_nettype wire

// file: verilog/cbt_quantum_prescaler.sv
/*
 * Time quantum generator: one tick every (field + 1) clocks.
 * Assumes the field and run come from registers on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module cbt_quantum_prescaler (
   input  wire logic aclk,
   input  wire logic aresetn,
   cbt_tq_if.gen     tq
);
   typedef struct packed {
      logic [cbt_pkg::PRESC_W-1:0] cnt;
      logic                        tick;
   } cbt_presc_state_type;

   cbt_presc_state_type s_r;
   cbt_presc_state_type s_nxt;

   // ==========================================================
   // Divider
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (!aresetn || !tq.run) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt >= tq.presc_field) begin
         s_nxt.cnt = '0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + cbt_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   assign tq.tick = s_r.tick;

   // ==========================================================
   // Checks
   AST_QUANTUM_SPACING: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_r.tick && tq.run && tq.presc_field != '0 && $stable(tq.presc_field)) |=> !s_r.tick)
      else $error("quantum ticks closer than prescaler allows");
endmodule
`default_nettype wire

// file: verilog/cbt_bit_timing.sv
/*
 * Bit timing logic: AXI4-Lite registers, bus input synchroniser,
 * segment state machine, sample point and edge synchronisation.
 * Assumes the frame logic drives bus_idle on this clock and that
 * can_rx is the asynchronous receive pin of the transceiver.
 */
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cbt_bit_timing (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [cbt_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [cbt_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       can_rx,
   input  wire logic                       bus_idle,
   output logic                            sample_point,
   output logic                            sampled_bit
);
   typedef struct packed {
      logic                               awready;
      logic                               wready;
      logic                               bvalid;
      logic [1:0]                         bresp;
      logic                               aw_hold;
      logic [cbt_pkg::ADDR_W-1:0]         awaddr;
      logic                               w_hold;
      logic [31:0]                        wdata;
      logic [3:0]                         wstrb;
      logic                               arready;
      logic                               rvalid;
      logic [31:0]                        rdata;
      logic [1:0]                         rresp;
      logic [31:0]                        btr;
      logic                               init;
      logic                               rx_meta;
      logic                               rx_sync;
      cbt_pkg::cbt_btl_state_type         st;
      logic [cbt_pkg::CNT_W-1:0]          cnt;
      logic [cbt_pkg::CNT_W-1:0]          lim1;
      logic [cbt_pkg::CNT_W-1:0]          lim2;
      logic                               prev_sp;
      logic                               synced;
      logic                               sample_point;
      logic                               sampled;
      logic                               hard_seen;
      logic                               resync_seen;
      logic signed [5:0]                  perr;
   } cbt_state_type;

   cbt_state_type             s_r;
   cbt_state_type             s_nxt;
   cbt_tq_if                  tq ();
   logic [cbt_pkg::CNT_W-1:0] first_timing_segment_field_nom;
   logic [cbt_pkg::CNT_W-1:0] ph2_nom;
   logic [cbt_pkg::CNT_W-1:0] sjw_raw;
   logic [cbt_pkg::CNT_W-1:0] sjw_eff;
   logic [cbt_pkg::CNT_W-1:0] pos_err;
   logic [cbt_pkg::CNT_W-1:0] pos_add;
   logic [cbt_pkg::CNT_W-1:0] neg_mag;
   logic [cbt_pkg::CNT_W-1:0] neg_sub;
   logic signed [5:0]         perr_now;
   logic                      edge_now;
   logic                      hard_now;

   localparam logic [4:0] CNT_ONE_L = cbt_pkg::CNT_ONE;

   function automatic logic [4:0] fn_min(input logic [4:0] a, input logic [4:0] b);
      fn_min = (a < b) ? a : b;
   endfunction

   function automatic logic [31:0] fn_strb(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      fn_strb = res;
   endfunction

   // ==========================================================
   // Configuration decode
   assign first_timing_segment_field_nom = 5'(s_r.btr[cbt_pkg::FIRST_TIMING_SEGMENT_FIELD_LSB +: cbt_pkg::FIRST_TIMING_SEGMENT_FIELD_W]) + cbt_pkg::CNT_ONE;
   assign ph2_nom   = 5'(s_r.btr[cbt_pkg::SECOND_TIMING_SEGMENT_FIELD_LSB +: cbt_pkg::SECOND_TIMING_SEGMENT_FIELD_W]) + cbt_pkg::CNT_ONE;
   assign sjw_raw   = 5'(s_r.btr[cbt_pkg::SJW_LSB +: cbt_pkg::SJW_W]) + cbt_pkg::CNT_ONE;
   assign sjw_eff   = fn_min(sjw_raw, ph2_nom);

   // ==========================================================
   // Edge detection and phase error
   assign edge_now = tq.tick && !s_r.init && !s_r.synced
                     && s_r.prev_sp == cbt_pkg::LVL_RECESSIVE
                     && s_r.rx_sync == cbt_pkg::LVL_DOMINANT;
   assign hard_now = edge_now && bus_idle;
   assign pos_err  = s_r.cnt + cbt_pkg::CNT_ONE;
   assign pos_add  = fn_min(pos_err, sjw_eff);
   assign neg_mag  = s_r.lim2 - s_r.cnt;
   assign neg_sub  = fn_min(neg_mag, sjw_eff);

   always_comb begin
      case (s_r.st)
         cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD: perr_now = $signed({1'b0, pos_err});
         cbt_pkg::ST_SECOND_TIMING_SEGMENT_FIELD: perr_now = -$signed({1'b0, neg_mag});
         default:           perr_now = '0;
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.rx_meta = can_rx;
      s_nxt.rx_sync = s_r.rx_meta;
      s_nxt.sample_point = 1'b0;

      // Write channel: address and data in either order
      if (s_r.awready && s_axi_awvalid) begin
         s_nxt.aw_hold = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_r.wready && s_axi_wvalid) begin
         s_nxt.w_hold = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
         s_nxt.aw_hold = 1'b0;
         s_nxt.w_hold = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = cbt_pkg::RESP_OKAY;
         case (s_r.awaddr)
            cbt_pkg::OFS_BIT_TIMING: begin
               s_nxt.btr = fn_strb(s_r.btr, s_r.wdata, s_r.wstrb) & cbt_pkg::BTR_MASK;
            end
            cbt_pkg::OFS_CONTROL: begin
               if (s_r.wstrb[0]) begin
                  s_nxt.init = s_r.wdata[cbt_pkg::CTRL_INIT_BIT];
               end
            end
            cbt_pkg::OFS_STATUS: begin
               if (s_r.wstrb[0] && s_r.wdata[cbt_pkg::STAT_HARD_BIT]) begin
                  s_nxt.hard_seen = 1'b0;
               end
               if (s_r.wstrb[0] && s_r.wdata[cbt_pkg::STAT_RESYNC_BIT]) begin
                  s_nxt.resync_seen = 1'b0;
               end
            end
            default: begin
               s_nxt.bresp = cbt_pkg::RESP_SLVERR;
            end
         endcase
      end
      s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_hold && !s_nxt.bvalid;

      // Read channel
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_r.arready && s_axi_arvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = cbt_pkg::RESP_OKAY;
         s_nxt.rdata = '0;
         case (s_axi_araddr)
            cbt_pkg::OFS_BIT_TIMING: s_nxt.rdata = s_r.btr;
            cbt_pkg::OFS_CONTROL:    s_nxt.rdata[cbt_pkg::CTRL_INIT_BIT] = s_r.init;
            cbt_pkg::OFS_STATUS: begin
               s_nxt.rdata[cbt_pkg::STAT_SAMPLE_BIT] = s_r.sampled;
               s_nxt.rdata[cbt_pkg::STAT_HARD_BIT] = s_r.hard_seen;
               s_nxt.rdata[cbt_pkg::STAT_RESYNC_BIT] = s_r.resync_seen;
               s_nxt.rdata[cbt_pkg::STAT_STATE_LSB +: 3] = s_r.st;
               s_nxt.rdata[cbt_pkg::STAT_PERR_LSB +: 6] = s_r.perr;
            end
            default: s_nxt.rresp = cbt_pkg::RESP_SLVERR;
         endcase
      end
      s_nxt.arready = !s_nxt.rvalid;

      // Bit timing state machine, one step per quantum; flag sets win
      if (s_r.init) begin
         s_nxt.st = cbt_pkg::ST_SYNC;
         s_nxt.cnt = '0;
         s_nxt.synced = 1'b0;
         s_nxt.prev_sp = cbt_pkg::LVL_RECESSIVE;
      end else if (tq.tick) begin
         if (edge_now) begin
            s_nxt.synced = 1'b1;
            s_nxt.perr = perr_now;
            if (hard_now) begin
               s_nxt.hard_seen = 1'b1;
            end else if (s_r.st != cbt_pkg::ST_SYNC) begin
               s_nxt.resync_seen = 1'b1;
            end
         end
         case (s_r.st)
            cbt_pkg::ST_SYNC: begin
               s_nxt.st = cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD;
               s_nxt.cnt = '0;
               s_nxt.lim1 = first_timing_segment_field_nom;
            end
            cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD: begin
               if (hard_now) begin
                  s_nxt.cnt = '0;
                  s_nxt.lim1 = first_timing_segment_field_nom;
               end else begin
                  if (edge_now) begin
                     s_nxt.lim1 = s_r.lim1 + pos_add;
                  end
                  if (pos_err >= s_nxt.lim1) begin
                     s_nxt.st = cbt_pkg::ST_SECOND_TIMING_SEGMENT_FIELD;
                     s_nxt.cnt = '0;
                     s_nxt.lim2 = ph2_nom;
                     s_nxt.sample_point = 1'b1;
                     s_nxt.sampled = s_r.rx_sync;
                     s_nxt.prev_sp = s_r.rx_sync;
                     s_nxt.synced = 1'b0;
                  end else begin
                     s_nxt.cnt = pos_err;
                  end
               end
            end
            cbt_pkg::ST_SECOND_TIMING_SEGMENT_FIELD: begin
               if (hard_now || (edge_now && neg_mag <= sjw_eff)) begin
                  s_nxt.st = cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD;
                  s_nxt.cnt = '0;
                  s_nxt.lim1 = first_timing_segment_field_nom;
               end else begin
                  if (edge_now) begin
                     s_nxt.lim2 = s_r.lim2 - neg_sub;
                  end
                  if (pos_err >= s_nxt.lim2) begin
                     s_nxt.st = cbt_pkg::ST_SYNC;
                     s_nxt.cnt = '0;
                  end else begin
                     s_nxt.cnt = pos_err;
                  end
               end
            end
            default: begin
               s_nxt.st = cbt_pkg::ST_SYNC;
               s_nxt.cnt = '0;
            end
         endcase
      end

      if (!aresetn) begin
         s_nxt = '0;
         s_nxt.st = cbt_pkg::ST_SYNC;
         s_nxt.btr = cbt_pkg::BTR_RST;
         s_nxt.init = 1'b1;
         s_nxt.rx_meta = cbt_pkg::LVL_RECESSIVE;
         s_nxt.rx_sync = cbt_pkg::LVL_RECESSIVE;
         s_nxt.prev_sp = cbt_pkg::LVL_RECESSIVE;
         s_nxt.sampled = cbt_pkg::LVL_RECESSIVE;
         s_nxt.lim1 = CNT_ONE_L;
         s_nxt.lim2 = CNT_ONE_L;
      end
   end

   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   // ==========================================================
   // Quantum prescaler and outputs
   assign tq.presc_field = s_r.btr[cbt_pkg::PRESC_LSB +: cbt_pkg::PRESC_W];
   assign tq.run = !s_r.init;

   cbt_quantum_prescaler u_presc (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tq      (tq.gen)
   );

   assign s_axi_awready = s_r.awready;
   assign s_axi_wready  = s_r.wready;
   assign s_axi_bvalid  = s_r.bvalid;
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid  = s_r.rvalid;
   assign s_axi_rdata   = s_r.rdata;
   assign s_axi_rresp   = s_r.rresp;
   assign sample_point  = s_r.sample_point;
   assign sampled_bit   = s_r.sampled;

   // ==========================================================
   // Checks
   logic [1:0] syncs_since_sp_r;
   always_ff @(posedge aclk) begin
      if (!aresetn || s_r.sample_point) begin
         syncs_since_sp_r <= '0;
      end else if (edge_now && syncs_since_sp_r != 2'h3) begin
         syncs_since_sp_r <= syncs_since_sp_r + 2'h1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_SYNC_ONE_QUANTUM: assert property (
      (s_r.st == cbt_pkg::ST_SYNC && tq.tick && !s_r.init) |=> s_r.st == cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD)
      else $error("sync segment not one quantum");
   AST_SAMPLE_AT_BOUNDARY: assert property (
      s_r.sample_point |-> (s_r.st == cbt_pkg::ST_SECOND_TIMING_SEGMENT_FIELD && $past(s_r.st) == cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD))
      else $error("sample point not between phase buffers");
   AST_SINGLE_SAMPLE: assert property (
      s_r.sample_point |=> !s_r.sample_point [*2])
      else $error("more than one sample per bit");
   AST_STEP_ON_QUANTUM: assert property (
      (s_r.st != $past(s_r.st)) |-> ($past(tq.tick) || $past(s_r.init)))
      else $error("state moved without a quantum");
   AST_NOMINAL_FIRST_TIMING_SEGMENT_FIELD: assert property (
      ($past(s_r.st) == cbt_pkg::ST_SYNC && s_r.st == cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD) |-> s_r.lim1 == $past(first_timing_segment_field_nom))
      else $error("first segment not nominal after sync");
   AST_NOMINAL_PH2: assert property (
      s_r.sample_point |-> s_r.lim2 == $past(ph2_nom))
      else $error("phase buffer two not nominal at sample");
   AST_SJW_BOUND: assert property (
      sjw_eff >= CNT_ONE_L && sjw_eff <= ph2_nom && sjw_eff <= 5'h04)
      else $error("jump width out of range");
   AST_LATE_EDGE: assert property (
      (edge_now && !hard_now && s_r.st == cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD) |=> s_r.lim1 == $past(s_r.lim1) + $past(pos_add)
      && s_r.perr > 0)
      else $error("late edge lengthening wrong");
   AST_EARLY_EDGE: assert property (
      (edge_now && !hard_now && s_r.st == cbt_pkg::ST_SECOND_TIMING_SEGMENT_FIELD && neg_mag <= sjw_eff)
      |=> (s_r.st == cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD && s_r.cnt == '0 && s_r.perr < 0))
      else $error("early edge not absorbed");
   AST_HARD_RESTART: assert property (
      hard_now |=> (s_r.st == cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD && s_r.cnt == '0 && s_r.hard_seen))
      else $error("hard sync did not restart bit");
   AST_ONE_SYNC: assert property (
      syncs_since_sp_r <= 2'h1)
      else $error("two synchronisations between sample points");

   COV_HARD: cover property (hard_now ##[1:40] s_r.sample_point);
   COV_LATE: cover property (edge_now && !hard_now && s_r.st == cbt_pkg::ST_FIRST_TIMING_SEGMENT_FIELD);
   COV_EARLY: cover property (edge_now && !hard_now && s_r.st == cbt_pkg::ST_SECOND_TIMING_SEGMENT_FIELD);
   COV_DOMINANT: cover property (s_r.sample_point && s_r.sampled == cbt_pkg::LVL_DOMINANT);
endmodule
`default_nettype wire

// file: tb/cbt_node_model.sv
/* Far CAN node: drives the receive line, recessive when released.
   Assumes the bench clock; changes follow a rising edge. */
`timescale 1ns/10ps
`default_nettype none
module cbt_node_model (
   input  wire logic aclk,
   output var logic  can_rx
);
   initial can_rx = cbt_pkg::LVL_RECESSIVE;
   // Drive a level, hold it a number of clocks
   task automatic put(input logic lvl, input int hold);
      @(posedge aclk);
      can_rx <= lvl;
      repeat (hold) @(posedge aclk);
   endtask
endmodule
`default_nettype wire

// file: tb/cbt_bit_timing_tb_top.sv
/* Bench for the bit timing block: registers, bit length, synchronisation.
   Assumes the node model drives can_rx; bready and rready stay high. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module cbt_bit_timing_tb_top;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, bus_idle = 0;
   logic [3:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, d;
   logic [1:0] r;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic sample_point, sampled_bit, can_rx;
   int error_cnt = 0, n_compared = 0, g;
   cbt_node_model node_u (.aclk(aclk), .can_rx(can_rx));
   cbt_bit_timing dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(1'b1), .can_rx(can_rx), .bus_idle(bus_idle),
      .sample_point(sample_point), .sampled_bit(sampled_bit));
   initial begin
      forever #20 aclk = ~aclk;
   end
   task automatic close_out();
      $display("compared=%0d errors=%0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic to();
      error_cnt++;
      close_out();
   endtask
   // ==========================================================
   // Register bus
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      int n;
      logic pa, pd;
      pa = 1;
      pd = 1;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 50 && (pa || pd); n++) begin
         @(posedge aclk);
         if (pa && s_axi_awready) begin awvalid <= 1'b0; pa = 0; end
         if (pd && s_axi_wready) begin wvalid <= 1'b0; pd = 0; end
      end
      n = 0;
      do begin @(posedge aclk); n++; end while (!s_axi_bvalid && n < 50);
      r = s_axi_bresp;
      if (n >= 50) to();
   endtask
   task automatic rd(input logic [3:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      do begin @(posedge aclk); n++; end while (!s_axi_arready && n < 50);
      arvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (!s_axi_rvalid && n < 100);
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n >= 100) to();
   endtask
   // Clocks between two sample point pulses
   task automatic gap();
      int n;
      n = 0;
      do begin @(posedge aclk); n++; end while (!sample_point && n < 500);
      g = 0;
      do begin @(posedge aclk); g++; end while (!sample_point && g < 500);
      if (n >= 500 || g >= 500) to();
   endtask
   // ==========================================================
   // Scenarios
   task automatic s_regs();
      rd(cbt_pkg::OFS_BIT_TIMING);
      `CHK(d, cbt_pkg::BTR_RST)
      wr(cbt_pkg::OFS_BIT_TIMING, 32'hFFFF_FFFF);
      `CHK(r, cbt_pkg::RESP_OKAY)
      rd(cbt_pkg::OFS_BIT_TIMING);
      `CHK(d, cbt_pkg::BTR_MASK)
      rd(4'hC);
      `CHK({r, d}, {cbt_pkg::RESP_SLVERR, 32'h0000_0000})
      wr(4'hC, 32'h0000_0000);
      `CHK(r, cbt_pkg::RESP_SLVERR)
      wr(cbt_pkg::OFS_CONTROL, 32'h0000_0000);
   endtask
   task automatic s_bits();
      logic [31:0] cfg [4] = '{32'h0000_2300, 32'h0000_2301, 32'h0000_7700, 32'h0000_7F00};
      int exp [4] = '{8, 16, 17, cbt_pkg::MIN_CLKS_PER_BIT};
      for (int i = 0; i < 4; i++) begin
         wr(cbt_pkg::OFS_BIT_TIMING, cfg[i]);
         gap();
         gap();
         `CHK(g, exp[i])
      end
      wr(cbt_pkg::OFS_BIT_TIMING, 32'h0000_2300);
      gap();
      `CHK(sampled_bit, cbt_pkg::LVL_RECESSIVE)
   endtask
   task automatic s_sync();
      bus_idle <= 1'b1;
      node_u.put(cbt_pkg::LVL_DOMINANT, 3);
      bus_idle <= 1'b0;
      gap();
      `CHK(sampled_bit, cbt_pkg::LVL_DOMINANT)
      rd(cbt_pkg::OFS_STATUS);
      `CHK(d[2:1], 2'h1)
      wr(cbt_pkg::OFS_STATUS, 32'h0000_0006);
      node_u.put(cbt_pkg::LVL_RECESSIVE, 0);
      gap();
      gap();
      `CHK(g, 8)
      rd(cbt_pkg::OFS_STATUS);
      `CHK(d[2:1], 2'h0)
      node_u.put(cbt_pkg::LVL_DOMINANT, 0);
      gap();
      rd(cbt_pkg::OFS_STATUS);
      `CHK(d[2:1], 2'h2)
      gap();
      gap();
      `CHK(g, 8)
   endtask
   // Edge in the last quantum of phase two: bit of 8 less a jump width of 1
   task automatic s_early();
      wr(cbt_pkg::OFS_STATUS, 32'h0000_0006);
      node_u.put(cbt_pkg::LVL_RECESSIVE, 0);
      gap();
      repeat (6) @(posedge aclk);
      node_u.put(cbt_pkg::LVL_DOMINANT, 0);
      gap();
      `CHK(g, 7)
      rd(cbt_pkg::OFS_STATUS);
      `CHK(d[2:1], 2'h2)
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      s_regs();
      s_bits();
      s_sync();
      s_early();
      close_out();
   end
endmodule
`default_nettype wire
